// [rtl/hdtc_pkg.sv]
// package: constants shared by the signalling transmit controller ends
package hdtc_pkg;
	// ----------------------------------------
	// command byte bit positions
	// ----------------------------------------
	localparam int CMD_W           = 8;
	localparam int CMD_SIG_RST_BIT = 0;                // signaling_tx_reset_cmd
	localparam int CMD_MSG_END_BIT = 1;                // message_end_cmd
	localparam int CMD_TRANSP_BIT  = 2;                // transparent_frame_cmd
	localparam int CMD_HDLC_BIT    = 3;                // hdlc_frame_send_cmd
	localparam int CMD_TX_RST_BIT  = 4;                // transmitter_reset_cmd
	localparam int CMD_REPEAT_BIT  = 5;                // repeat_tx_cmd

	// ----------------------------------------
	// line patterns and counts
	// ----------------------------------------
	localparam logic [7:0]  FLAG_BYTE  = 8'h7E;
	localparam logic [7:0]  ABORT_BYTE = 8'h7F;
	localparam logic [3:0]  BYTE_LEN   = 4'h8;
	localparam logic [3:0]  ABORT_LEN  = 4'h7;        // seven ones
	localparam logic [2:0]  STUFF_RUN  = 3'h5;
	localparam logic [15:0] CRC_INIT   = 16'hFFFF;
	localparam logic [15:0] CRC_POLY   = 16'h8408;    // reflected ccitt
	localparam int          FIFO_DEPTH = 8;
	localparam int          MAX_BLOCK  = 32;

	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int CLK_PERIOD_PS = 4000;
	localparam int CLK_LOSS_PS   = 2000000;            // silence that counts as a lost clock
	localparam int CLK_LOSS_CYC  = (CLK_LOSS_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

	// ----------------------------------------
	// host register map and status fields
	// ----------------------------------------
	localparam int          ADDR_W     = 4;
	localparam logic [3:0]  REG_CMD    = 4'h0;
	localparam logic [3:0]  REG_TXDATA = 4'h4;
	localparam logic [3:0]  REG_STATUS = 4'h8;
	localparam int          ST_CEC     = 0;
	localparam int          ST_CLKLOST = 1;
	localparam int          ST_POOL    = 2;
	localparam int          ST_REFUSED = 3;
	localparam int          ST_OVFL    = 4;
	localparam int          ST_CNT_LSB = 8;
	localparam logic [1:0]  RESP_OKAY  = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;

	// transmitter unit states
	typedef enum logic [2:0] {
		ST_IDLE   = 3'b000,
		ST_OPEN   = 3'b001,
		ST_DATA   = 3'b010,
		ST_CRC1   = 3'b011,
		ST_CRC2   = 3'b100,
		ST_CLOSE  = 3'b101,
		ST_TRANSP = 3'b110,
		ST_ABORT  = 3'b111
	} hdtc_st_t;
endpackage

// [rtl/hdtc_if.sv]
// interface: link between host controller and signalling transmitter
`timescale 1ns/1ps
`default_nettype none
interface hdtc_if;
	logic       cmd_valid;
	logic [7:0] cmd_data;
	logic       cmd_ready;
	logic       fifo_valid;
	logic [7:0] fifo_data;
	logic       fifo_ready;
	logic       cec;
	logic       clk_lost;
	logic       pool_ready;

	modport dev (input cmd_valid, cmd_data, fifo_valid, fifo_data,
	             output cmd_ready, fifo_ready, cec, clk_lost, pool_ready);
	modport host (output cmd_valid, cmd_data, fifo_valid, fifo_data,
	              input cmd_ready, fifo_ready, cec, clk_lost, pool_ready);
endinterface
`default_nettype wire

// [rtl/hdtc_dev.sv]
// signalling transmitter: command register, transmit fifo, serializer
//
// Function
// R1 - transparent command sends fifo bytes unframed
// R2 - message end appends crc and closing flag
// R3 - signalling reset resets transmitter, flushes fifo
// R4 - after reset send seven ones then fill
// R5 - reset completion pulses pool ready to host
// R6 - host may abort frame with signalling reset
// R7 - command executes within 2.5 data periods
// R8 - host polls executing flag before writing commands
// R9 - host commands only while transmit clock runs
// R10 - missing clock blocks register after a command
// R11 - host writes at most 32 bytes per frame
// R12 - repeat with transparent cycles fifo until stopped
// R13 - command bits are single shot strobes
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// fifo
// ----------------------------------------
module hdtc_fifo #(
	parameter int W = 8,
	parameter int D = 8
) (
	input  wire logic         aclk,
	input  wire logic         aresetn,
	input  wire logic         flush,
	input  wire logic         in_valid,
	input  wire logic [W-1:0] in_data,
	output logic              in_ready,
	output logic              out_valid,
	output logic [W-1:0]      out_data,
	input  wire logic         out_ready
);
	localparam int AW = (D > 1) ? $clog2(D) : 1;
	localparam int CW = $clog2(D + 1);

	logic [W-1:0]  mem_q [D];
	logic [AW-1:0] wp_q;
	logic [AW-1:0] rp_q;
	logic [CW-1:0] cnt_q;
	wire           push = in_valid & in_ready;
	wire           pop  = out_valid & out_ready;

	// a pop frees a slot in the same cycle
	assign out_valid = cnt_q != '0;
	assign in_ready  = (cnt_q != CW'(D)) | pop;
	assign out_data  = mem_q[rp_q];

	// storage, no reset needed
	always_ff @(posedge aclk) begin
		if (push) begin
			mem_q[wp_q] <= in_data;
		end
	end

	// pointers and fill count
	always_ff @(posedge aclk) begin
		if (!aresetn || flush) begin
			wp_q  <= '0;
			rp_q  <= '0;
			cnt_q <= '0;
		end else begin
			if (push) wp_q <= (wp_q == AW'(D - 1)) ? '0 : wp_q + 1'b1;
			if (pop) rp_q <= (rp_q == AW'(D - 1)) ? '0 : rp_q + 1'b1;
			if (push && !pop) cnt_q <= cnt_q + 1'b1;
			else if (pop && !push) cnt_q <= cnt_q - 1'b1;
		end
	end
endmodule

// ----------------------------------------
// device end
// ----------------------------------------
module hdtc_dev
	import hdtc_pkg::*;
#(
	parameter int CLK_LOSS = hdtc_pkg::CLK_LOSS_CYC,
	parameter int DEPTH    = hdtc_pkg::FIFO_DEPTH
) (
	input  wire logic aclk,
	input  wire logic aresetn,
	hdtc_if.dev       link,
	input  wire logic system_tx_clock,
	output logic      tx_line_q,
	output logic      tx_strobe_q
);
	import hdtc_pkg::*;
	localparam int LW = $clog2(CLK_LOSS + 1);

	logic           sclk_s1_q, sclk_s2_q, sclk_s3_q;
	logic [LW-1:0]  loss_cnt_q;
	logic           clk_lost_q;
	logic [7:0]     pend_q, pend_d;
	logic           cec_q, cmd_ready_q, pool_q;
	hdtc_st_t       state_q, ld_st, cur_st;
	logic [7:0]     sh_q, ld_byte, cur_byte;
	logic [3:0]     left_q, ld_len, cur_left;
	logic [2:0]     ones_q;
	logic [15:0]    crc_q;
	logic           msg_end_q, repeat_q, pop_sel;
	logic           f_in_ready, f_out_valid;
	logic [7:0]     f_out_data;

	// ----------------------------------------
	// transmit clock: sync, edge, loss watch
	// ----------------------------------------
	wire tick = sclk_s2_q & ~sclk_s3_q;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sclk_s1_q  <= 1'b0;
			sclk_s2_q  <= 1'b0;
			sclk_s3_q  <= 1'b0;
			loss_cnt_q <= '0;
			clk_lost_q <= 1'b0;
		end else begin
			sclk_s1_q  <= system_tx_clock;
			sclk_s2_q  <= sclk_s1_q;
			sclk_s3_q  <= sclk_s2_q;
			loss_cnt_q <= tick ? '0 : (loss_cnt_q == LW'(CLK_LOSS)) ? loss_cnt_q : loss_cnt_q + 1'b1;
			clk_lost_q <= !tick && (loss_cnt_q == LW'(CLK_LOSS));
		end
	end

	// ----------------------------------------
	// command register and decode
	// ----------------------------------------
	wire take     = link.cmd_valid & cmd_ready_q;
	wire exec     = tick & cec_q;                             // [R7] next data edge, held while clock lost [R10]
	wire c_rst    = exec & (pend_q[CMD_SIG_RST_BIT] | pend_q[CMD_TX_RST_BIT]);
	wire c_hdlc   = exec & pend_q[CMD_HDLC_BIT] & ~c_rst;
	wire c_trn    = exec & pend_q[CMD_TRANSP_BIT] & ~c_rst & ~pend_q[CMD_HDLC_BIT];
	wire c_me     = exec & pend_q[CMD_MSG_END_BIT] & ~c_rst;
	wire exec_any = c_rst | c_hdlc | c_trn;
	wire rep_now  = c_trn ? pend_q[CMD_REPEAT_BIT] : repeat_q;

	assign pend_d = take ? link.cmd_data : exec ? '0 : pend_q; // [R13]

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pend_q      <= '0;
			cec_q       <= 1'b0;
			cmd_ready_q <= 1'b1;
			pool_q      <= 1'b0;
		end else begin
			pend_q      <= pend_d;
			cec_q       <= |pend_d;
			cmd_ready_q <= ~|pend_d;                          // [R10]
			pool_q      <= c_rst;                             // [R5]
		end
	end

	assign link.cmd_ready  = cmd_ready_q;
	assign link.cec        = cec_q;
	assign link.clk_lost   = clk_lost_q;
	assign link.pool_ready = pool_q;

	// ----------------------------------------
	// next unit selection
	// ----------------------------------------
	always_comb begin
		ld_st   = ST_IDLE;
		ld_byte = FLAG_BYTE;
		ld_len  = BYTE_LEN;
		pop_sel = 1'b0;
		if (c_rst) begin
			ld_st   = ST_ABORT;                               // [R3] [R4] [R6]
			ld_byte = ABORT_BYTE;
			ld_len  = ABORT_LEN;
		end else if (c_hdlc) begin
			ld_st = ST_OPEN;                                  // [R11]
		end else if (c_trn || state_q == ST_TRANSP) begin
			if (f_out_valid) begin
				ld_st   = ST_TRANSP;                          // [R1]
				ld_byte = f_out_data;
				pop_sel = 1'b1;
			end
		end else begin
			unique case (state_q)
				ST_OPEN, ST_DATA: begin
					if (f_out_valid) begin
						ld_st   = ST_DATA;
						ld_byte = f_out_data;
						pop_sel = 1'b1;
					end else if (msg_end_q) begin
						ld_st   = ST_CRC1;                    // [R2]
						ld_byte = ~crc_q[7:0];
					end else begin
						ld_st   = ST_ABORT;
						ld_byte = ABORT_BYTE;
						ld_len  = ABORT_LEN;
					end
				end
				ST_CRC1: begin
					ld_st   = ST_CRC2;
					ld_byte = ~crc_q[15:8];
				end
				ST_CRC2: ld_st = ST_CLOSE;                    // [R2]
				ST_IDLE, ST_CLOSE, ST_ABORT, ST_TRANSP: ld_st = ST_IDLE;
			endcase
		end
	end

	// ----------------------------------------
	// serializer
	// ----------------------------------------
	wire body      = (state_q == ST_DATA) | (state_q == ST_CRC1) | (state_q == ST_CRC2);
	wire stuff_now = tick & body & (ones_q == STUFF_RUN) & ~exec_any;
	wire do_load   = tick & ~stuff_now & (exec_any | (left_q == '0));
	wire pop       = do_load & pop_sel;
	wire recirc    = pop & rep_now & (ld_st == ST_TRANSP);   // [R12]
	wire cur_body  = (cur_st == ST_DATA) | (cur_st == ST_CRC1) | (cur_st == ST_CRC2);
	wire bit_out   = cur_byte[0];
	wire crc_fb    = crc_q[0] ^ bit_out;

	assign cur_st   = do_load ? ld_st : state_q;
	assign cur_byte = do_load ? ld_byte : sh_q;
	assign cur_left = do_load ? ld_len : left_q;

	// line shift, stuffing and crc
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_q     <= ST_IDLE;
			sh_q        <= '0;
			left_q      <= '0;
			ones_q      <= '0;
			crc_q       <= CRC_INIT;
			tx_line_q   <= 1'b1;
			tx_strobe_q <= 1'b0;
		end else begin
			tx_strobe_q <= tick;
			if (stuff_now) begin
				tx_line_q <= 1'b0;                            // zero after five ones
				ones_q    <= '0;
			end else if (tick) begin
				state_q   <= cur_st;
				tx_line_q <= bit_out;
				sh_q      <= {1'b0, cur_byte[7:1]};
				left_q    <= cur_left - 1'b1;
				ones_q    <= (cur_body && bit_out) ? ones_q + 1'b1 : '0;
				if (cur_st == ST_OPEN) crc_q <= CRC_INIT;
				else if (cur_st == ST_DATA) crc_q <= (crc_q >> 1) ^ (crc_fb ? CRC_POLY : 16'h0000);
			end
		end
	end

	// message end and repeat latches
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			msg_end_q <= 1'b0;
			repeat_q  <= 1'b0;
		end else begin
			if (c_me) msg_end_q <= 1'b1;                      // [R2]
			else if (exec_any || (do_load && ld_st == ST_CRC1)) msg_end_q <= 1'b0;
			if (exec) repeat_q <= c_trn & pend_q[CMD_REPEAT_BIT]; // [R12]
		end
	end

	// ----------------------------------------
	// transmit fifo, refilled from itself in repeat mode
	// ----------------------------------------
	assign link.fifo_ready = f_in_ready & ~recirc & ~c_rst;

	hdtc_fifo #(.W(8), .D(DEPTH)) u_fifo (
		.aclk      (aclk),
		.aresetn   (aresetn),
		.flush     (c_rst),                                   // [R3]
		.in_valid  (recirc | link.fifo_valid),
		.in_data   (recirc ? f_out_data : link.fifo_data),
		.in_ready  (f_in_ready),
		.out_valid (f_out_valid),
		.out_data  (f_out_data),
		.out_ready (pop)
	);
endmodule
`default_nettype wire

// [rtl/hdtc_host.sv]
// host controller: axi4-lite registers driving the signalling transmitter
`timescale 1ns/1ps
`default_nettype none
module hdtc_host
	import hdtc_pkg::*;
(
	input  wire logic                        aclk,
	input  wire logic                        aresetn,
	input  wire logic [hdtc_pkg::ADDR_W-1:0] s_awaddr,
	input  wire logic                        s_awvalid,
	output logic                             s_awready,
	input  wire logic [31:0]                 s_wdata,
	input  wire logic [3:0]                  s_wstrb,
	input  wire logic                        s_wvalid,
	output logic                             s_wready,
	output logic [1:0]                       s_bresp,
	output logic                             s_bvalid,
	input  wire logic                        s_bready,
	input  wire logic [hdtc_pkg::ADDR_W-1:0] s_araddr,
	input  wire logic                        s_arvalid,
	output logic                             s_arready,
	output logic [31:0]                      s_rdata,
	output logic [1:0]                       s_rresp,
	output logic                             s_rvalid,
	input  wire logic                        s_rready,
	hdtc_if.host                             link
);
	import hdtc_pkg::*;

	logic [ADDR_W-1:0] aw_addr_q;
	logic [31:0]       w_data_q;
	logic              w_lane0_q;
	logic              cmd_valid_q, fifo_valid_q;
	logic [7:0]        cmd_data_q, fifo_data_q;
	logic [5:0]        blk_cnt_q;
	logic              pool_q, refused_q, ovfl_q;

	// ----------------------------------------
	// write decode
	// ----------------------------------------
	wire busy     = cmd_valid_q | fifo_valid_q | s_bvalid;
	wire start    = ~s_awready & ~s_wready & ~busy;
	wire sel_cmd  = aw_addr_q == REG_CMD;
	wire sel_dat  = aw_addr_q == REG_TXDATA;
	wire sel_sts  = aw_addr_q == REG_STATUS;
	wire cmd_go   = start & sel_cmd & w_lane0_q & ~link.clk_lost;   // [R9]
	wire cmd_drop = start & sel_cmd & w_lane0_q & link.clk_lost;
	wire blk_full = blk_cnt_q == 6'(MAX_BLOCK);
	wire dat_go   = start & sel_dat & w_lane0_q & ~blk_full;        // [R11]
	wire dat_drop = start & sel_dat & w_lane0_q & blk_full;
	wire cmd_done = cmd_valid_q & link.cmd_ready;                   // [R8] waits out busy device
	wire dat_done = fifo_valid_q & link.fifo_ready;
	wire frame_go = cmd_done & (cmd_data_q[CMD_HDLC_BIT] | cmd_data_q[CMD_TRANSP_BIT]
	                | cmd_data_q[CMD_SIG_RST_BIT] | cmd_data_q[CMD_TX_RST_BIT]);
	wire sts_clr  = start & sel_sts & w_lane0_q;
	wire [31:0] sts_word = {18'h0, blk_cnt_q, 3'h0, ovfl_q, refused_q, pool_q,
	                        link.clk_lost, link.cec | cmd_valid_q};

	// address and data capture, either order
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_awready <= 1'b1;
			s_wready  <= 1'b1;
			aw_addr_q <= '0;
			w_data_q  <= '0;
			w_lane0_q <= 1'b0;
		end else begin
			if (s_awvalid && s_awready) begin
				s_awready <= 1'b0;
				aw_addr_q <= s_awaddr;
			end else if (start) s_awready <= 1'b1;
			if (s_wvalid && s_wready) begin
				s_wready  <= 1'b0;
				w_data_q  <= s_wdata;
				w_lane0_q <= s_wstrb[0];
			end else if (start) s_wready <= 1'b1;
		end
	end

	// link requests and write response
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cmd_valid_q  <= 1'b0;
			cmd_data_q   <= '0;
			fifo_valid_q <= 1'b0;
			fifo_data_q  <= '0;
			s_bvalid     <= 1'b0;
			s_bresp      <= RESP_OKAY;
		end else begin
			if (cmd_go) begin
				cmd_valid_q <= 1'b1;
				cmd_data_q  <= w_data_q[7:0];
			end else if (cmd_done) cmd_valid_q <= 1'b0;
			if (dat_go) begin
				fifo_valid_q <= 1'b1;
				fifo_data_q  <= w_data_q[7:0];
			end else if (dat_done) fifo_valid_q <= 1'b0;
			if (cmd_done || dat_done || (start && !cmd_go && !dat_go)) begin
				s_bvalid <= 1'b1;
				s_bresp  <= (start && !(sel_cmd || sel_dat || sel_sts)) ? RESP_SLVERR : RESP_OKAY;
			end else if (s_bready) s_bvalid <= 1'b0;
		end
	end

	// block count and sticky status, set wins over write-one-to-clear
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			blk_cnt_q <= '0;
			pool_q    <= 1'b0;
			refused_q <= 1'b0;
			ovfl_q    <= 1'b0;
		end else begin
			if (frame_go) blk_cnt_q <= '0;
			else if (dat_done) blk_cnt_q <= blk_cnt_q + 1'b1;
			pool_q    <= link.pool_ready | (pool_q & ~(sts_clr & w_data_q[ST_POOL]));
			refused_q <= cmd_drop | (refused_q & ~(sts_clr & w_data_q[ST_REFUSED]));
			ovfl_q    <= dat_drop | (ovfl_q & ~(sts_clr & w_data_q[ST_OVFL]));
		end
	end

	assign link.cmd_valid  = cmd_valid_q;
	assign link.cmd_data   = cmd_data_q;
	assign link.fifo_valid = fifo_valid_q;
	assign link.fifo_data  = fifo_data_q;

	// ----------------------------------------
	// read channel
	// ----------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_arready <= 1'b1;
			s_rvalid  <= 1'b0;
			s_rdata   <= '0;
			s_rresp   <= RESP_OKAY;
		end else if (s_arvalid && s_arready) begin
			s_arready <= 1'b0;
			s_rvalid  <= 1'b1;
			s_rdata   <= (s_araddr == REG_STATUS) ? sts_word
			           : (s_araddr == REG_CMD) ? {24'h0, cmd_data_q} : 32'h0;
			s_rresp   <= (s_araddr == REG_STATUS || s_araddr == REG_CMD) ? RESP_OKAY : RESP_SLVERR;
		end else if (s_rvalid && s_rready) begin
			s_rvalid  <= 1'b0;
			s_arready <= 1'b1;
		end
	end
endmodule
`default_nettype wire

// [verification/hdtc_asserts.sv]
// checker: link handshake and command timing properties
`timescale 1ns/1ps
`default_nettype none
module hdtc_asserts (
	input wire logic       aclk,
	input wire logic       aresetn,
	input wire logic       cmd_valid,
	input wire logic [7:0] cmd_data,
	input wire logic       cmd_ready,
	input wire logic       fifo_valid,
	input wire logic [7:0] fifo_data,
	input wire logic       fifo_ready,
	input wire logic       cec,
	input wire logic       clk_lost,
	input wire logic       pool_ready
);
	localparam int EXEC_MAX = 20; // 2.5 line bits of 8 cycles
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// ----------------------------------------
	// command handshake
	// ----------------------------------------
	chk_cmd_taken: assert property (cmd_valid && cmd_ready && cmd_data != 8'h00 |=> !cmd_ready && cec)
		else $error("taken command not marked pending");
	chk_zero_noop: assert property (cmd_valid && cmd_ready && cmd_data == 8'h00 |=> cmd_ready && !cec)
		else $error("empty command left something pending");
	chk_cmd_drop: assert property (cmd_valid && cmd_ready |=> !cmd_valid)
		else $error("command strobe not withdrawn");
	chk_cmd_hold: assert property (cmd_valid && !cmd_ready |=> cmd_valid && $stable(cmd_data))
		else $error("command dropped while device busy");
	chk_cec_mirror: assert property (cec == !cmd_ready)
		else $error("executing flag differs from pending");
	chk_no_self: assert property (!cec && !(cmd_valid && cmd_ready) |=> !cec)
		else $error("command executing without a write");
	chk_exec_bound: assert property ($rose(cec) && !clk_lost |-> ##[1:EXEC_MAX] (!cec || clk_lost))
		else $error("command not executed in time");
	// ----------------------------------------
	// fifo and pool ready
	// ----------------------------------------
	chk_fifo_hold: assert property (fifo_valid && !fifo_ready |=> fifo_valid && $stable(fifo_data))
		else $error("fifo byte dropped before taken");
	chk_pool_pulse: assert property (pool_ready |=> !pool_ready)
		else $error("pool ready longer than one cycle");
	chk_pool_cause: assert property (pool_ready |-> $past(cec) || $past(cec, 2))
		else $error("pool ready without a command");
	cov_pool: cover property (pool_ready);
	cov_full: cover property (fifo_valid && !fifo_ready);
	cov_lost_cmd: cover property (clk_lost && cec);
endmodule
`default_nettype wire

// [verification/hdlc_tx_command_control_tb.sv]
// testbench: host registers driving the signalling transmitter
`timescale 1ns/1ps
`default_nettype none
module hdlc_tx_command_control_tb;
	import hdtc_pkg::*;
	logic        aclk = 1'b0, aresetn = 1'b0, stx = 1'b0, sclk_run = 1'b0;
	logic [3:0]  s_awaddr = 4'h0, s_araddr = 4'h0, s_wstrb = 4'hF;
	logic [31:0] s_wdata = 32'h0, s_rdata, lf = 32'h0000CA64;
	logic        s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0, s_arvalid = 1'b0, s_rready = 1'b0;
	logic        s_awready, s_wready, s_bvalid, s_arready, s_rvalid, tx_line_q, tx_strobe_q;
	logic [1:0]  s_bresp, s_rresp;
	logic [2:0]  div = 3'h0;
	logic [7:0]  b [0:7];
	logic [15:0] crc;
	logic        bits[$], expq[$];
	int          bad_count = 0, checks_done = 0, ones = 0;

	hdtc_if hdtc_if_i ();
	hdtc_host hdtc_host_i (.aclk(aclk), .aresetn(aresetn), .s_awaddr(s_awaddr), .s_awvalid(s_awvalid),
		.s_awready(s_awready), .s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid), .s_wready(s_wready),
		.s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid),
		.s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready),
		.link(hdtc_if_i));
	hdtc_dev #(.CLK_LOSS(20)) hdtc_dev_i (.aclk(aclk), .aresetn(aresetn), .link(hdtc_if_i),
		.system_tx_clock(stx), .tx_line_q(tx_line_q), .tx_strobe_q(tx_strobe_q));
	hdtc_asserts hdtc_asserts_i (.aclk(aclk), .aresetn(aresetn), .cmd_valid(hdtc_if_i.cmd_valid),
		.cmd_data(hdtc_if_i.cmd_data), .cmd_ready(hdtc_if_i.cmd_ready), .fifo_valid(hdtc_if_i.fifo_valid),
		.fifo_data(hdtc_if_i.fifo_data), .fifo_ready(hdtc_if_i.fifo_ready), .cec(hdtc_if_i.cec),
		.clk_lost(hdtc_if_i.clk_lost), .pool_ready(hdtc_if_i.pool_ready));

	// ----------------------------------------
	// clocks, line capture
	// ----------------------------------------
	always #2 aclk = ~aclk;
	// line clock: one bit per 8 cycles, stands still when stopped
	always @(posedge aclk) begin
		if (sclk_run) begin
			div <= div + 3'h1;
			stx <= div[2];
		end
	end
	// collect each new line bit
	always @(posedge aclk) begin
		if (tx_strobe_q)
			bits.push_back(tx_line_q);
	end

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// true when the expected bits occur in the capture
	function automatic bit found();
		bit ok;
		for (int i = 0; i + expq.size() <= bits.size(); i++) begin
			ok = 1'b1;
			for (int j = 0; j < expq.size(); j++)
				if (bits[i+j] !== expq[j])
					ok = 1'b0;
			if (ok)
				return 1'b1;
		end
		return 1'b0;
	endfunction
	// frame check over the first n bytes, lsb first
	function automatic logic [15:0] crc16(input int n);
		logic [15:0] c;
		c = CRC_INIT;
		for (int i = 0; i < n; i++)
			for (int k = 0; k < 8; k++)
				c = (c[0] ^ b[i][k]) ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
		return ~c;
	endfunction
	// append a byte lsb first, zero after five ones when stuffed
	task automatic put(input logic [7:0] v, input bit stuff);
		for (int i = 0; i < 8; i++) begin
			expq.push_back(v[i]);
			ones = (v[i] && stuff) ? ones + 1 : 0;
			if (ones == STUFF_RUN) begin
				expq.push_back(1'b0);
				ones = 0;
			end
		end
	endtask
	task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic chk_seq(input bit want);
		chk32({31'h0, found()}, {31'h0, want});
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
		@(posedge aclk);
		s_awaddr <= a;
		s_wdata <= d;
		s_awvalid <= 1'b1;
		s_wvalid <= 1'b1;
		s_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_awready)
				s_awvalid <= 1'b0;
			if (s_wready)
				s_wvalid <= 1'b0;
		end while (!s_bvalid);
		chk32({30'h0, s_bresp}, {30'h0, er});
		s_bready <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [31:0] msk, input logic [31:0] exp, input logic [1:0] er);
		@(posedge aclk);
		s_araddr <= a;
		s_arvalid <= 1'b1;
		s_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_arready)
				s_arvalid <= 1'b0;
		end while (!s_rvalid);
		chk32(s_rdata & msk, exp);
		chk32({30'h0, s_rresp}, {30'h0, er});
		s_rready <= 1'b0;
	endtask
	// write n bytes, the first given, the rest random
	task automatic load(input int n, input logic [7:0] first);
		for (int i = 0; i < n; i++) begin
			lf = lfsr(lf);
			b[i] = (i == 0) ? first : lf[7:0];
			wr(REG_TXDATA, {24'h0, b[i]}, RESP_OKAY);
		end
	endtask
	task automatic cmd(input logic [7:0] c, input int n);
		bits.delete();
		wr(REG_CMD, {24'h0, c}, RESP_OKAY);
		while (bits.size() < n)
			@(posedge aclk);
		expq.delete();
		ones = 0;
	endtask
	task automatic finish_test();
		$display("checks_done=%0d bad_count=%0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		sclk_run <= 1'b1;
		rd(REG_STATUS, 32'hFFFF_FFFF, 32'h0, RESP_OKAY);
		rd(4'hC, 32'hFFFF_FFFF, 32'h0, RESP_SLVERR);
		wr(4'hC, 32'h1, RESP_SLVERR);
		$display("test registers done");
		load(8, 8'h00);
		chk32({31'h0, hdtc_if_i.fifo_ready}, 32'h0);
		rd(REG_STATUS, 32'hFFFF, 32'h0800, RESP_OKAY);
		cmd(8'h01, 40);
		for (int i = 0; i < ABORT_LEN; i++)
			expq.push_back(1'b1);
		put(FLAG_BYTE, 1'b0);
		put(FLAG_BYTE, 1'b0);
		chk_seq(1'b1);
		chk32({31'h0, hdtc_if_i.fifo_ready}, 32'h1);
		rd(REG_STATUS, 32'h1F, 32'h4, RESP_OKAY);
		wr(REG_STATUS, 32'h1C, RESP_OKAY);
		$display("test reset done");
		load(2, 8'hFF);
		cmd(8'h04, 48);
		put(b[0], 1'b0);
		put(b[1], 1'b0);
		chk_seq(1'b1);
		$display("test transparent done");
		load(3, 8'hFF);
		crc = crc16(3);
		cmd(8'h0A, 96);
		put(FLAG_BYTE, 1'b0);
		for (int i = 0; i < 3; i++)
			put(b[i], 1'b1);
		put(crc[7:0], 1'b1);
		put(crc[15:8], 1'b1);
		put(FLAG_BYTE, 1'b0);
		chk_seq(1'b1);
		$display("test frame done");
		load(2, 8'h5A);
		cmd(8'h24, 80);
		for (int i = 0; i < 4; i++)
			put(b[i % 2], 1'b0);
		chk_seq(1'b1);
		cmd(8'h01, 8);
		bits.delete();
		while (bits.size() < 32)
			@(posedge aclk);
		put(b[0], 1'b0);
		put(b[1], 1'b0);
		chk_seq(1'b0);
		wr(REG_STATUS, 32'h1C, RESP_OKAY);
		$display("test repeat done");
		// transparent run kept fed until the block limit refuses a byte
		for (int i = 0; i < FIFO_DEPTH; i++)
			wr(REG_TXDATA, 32'h0, RESP_OKAY);
		wr(REG_CMD, 32'h04, RESP_OKAY);
		for (int i = 0; i <= MAX_BLOCK; i++)
			wr(REG_TXDATA, 32'h0, RESP_OKAY);
		rd(REG_STATUS, 32'h3F1F, 32'h2010, RESP_OKAY);
		s_wstrb <= 4'h0;
		wr(REG_STATUS, 32'h1C, RESP_OKAY);
		s_wstrb <= 4'hF;
		rd(REG_STATUS, 32'h10, 32'h10, RESP_OKAY);
		wr(REG_STATUS, 32'h1C, RESP_OKAY);
		wr(REG_CMD, 32'h00, RESP_OKAY);
		rd(REG_STATUS, 32'h1F, 32'h0, RESP_OKAY);
		$display("test overflow done");
		@(posedge aclk);
		sclk_run <= 1'b0;
		repeat (10) @(posedge aclk);
		wr(REG_CMD, 32'h04, RESP_OKAY);
		repeat (40) @(posedge aclk);
		rd(REG_STATUS, 32'h1F, 32'h3, RESP_OKAY);
		wr(REG_CMD, 32'h04, RESP_OKAY);
		rd(REG_STATUS, 32'h1F, 32'hB, RESP_OKAY);
		sclk_run <= 1'b1;
		repeat (60) @(posedge aclk);
		rd(REG_STATUS, 32'h1F, 32'h8, RESP_OKAY);
		$display("test lost clock done");
		finish_test();
	end
	// watchdog well beyond the few thousand cycles the tests need
	initial begin
		repeat (30000) @(posedge aclk);
		bad_count++;
		finish_test();
	end
endmodule
`default_nettype wire
